// [hdl/calibrated_interval_timer.sv]
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - Each tick: nonzero debounce count decrements, zero skips to base counting.
// - Debounce reaching zero re-enables key edge and samples key pin.
// - Sampled low key means pressed: press count increments.
// - Sampled high key means not pressed: press count unchanged.
// - Press count past last table index wraps to zero.
// - Base count decrements each tick; interval decrements only at base zero.
// - Interval zero: reload from table, invert LED, select measurement.
// - Measurement starts with counter preloaded to wake offset plus one.
// - Measurement counter advances every 87 core clocks, offset covers wake.
// - Measurement-ending tick loads base with ticks closest to 100 ms, minus one.
// - After loading, base decrements once; debounce and base counting follow.
// - Key level examined only after nine ticks following key edge.
// - Watchdog runs from reset release, tick at 75 percent of overflow.
// - Debounce, press, base and interval counters and table are 8 bits.
// - Falling key edge loads debounce with nine, masks key edges.
// - Reset clears press count; table entry zero holds one.
module calibrated_interval_timer
#(
  parameter int TICK_CYCLES = interval_timer_pkg::WDT_TICK_CYC,
  parameter int BASE_RATIO  = interval_timer_pkg::BASE_RATIO,
  parameter int TABLE_DEPTH = interval_timer_pkg::TABLE_MAX
)
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        key_pin,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             led,
  output logic             irq
);
  import interval_timer_pkg::*;

  localparam int IW = (TABLE_DEPTH > 1) ? $clog2(TABLE_DEPTH) : 1;
  localparam logic [7:0] LAST_IDX = 8'(TABLE_DEPTH - 1);
  localparam int SW = $clog2(MEAS_STEP_CYC + 1);
  localparam logic [SW-1:0] STEP_LAST = SW'(MEAS_STEP_CYC - 1);

  fsm_state_t    state;
  handler_t      handler_select;
  logic [7:0]    debounce_count;
  logic [7:0]    press_count;
  logic [7:0]    base_tick_count;
  logic [7:0]    period_count;
  logic [7:0]    interval_table [0:TABLE_DEPTH-1];
  logic [15:0]   measure_counter;
  logic [SW-1:0] step_count;
  logic          key_irq_en;
  logic          key_meta;
  logic          key_sync;
  logic          key_prev;
  logic [STATUS_W-1:0] status;
  logic [STATUS_W-1:0] mask;

  logic          key_fall;
  logic          base_expire;
  logic          interval_done;
  logic [7:0]    next_period;
  logic [7:0]    next_press;
  logic [7:0]    calc_value;
  logic [31:0]   quotient;
  logic          ev_press;
  logic          ev_interval;
  logic          ev_calib;
  logic [STATUS_W-1:0] w1c;

  wdt_if wdt ();

  // Watchdog interval tick source
  watchdog_unit #(.TICK_CYCLES(TICK_CYCLES)) u_wdt
  (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .wdt     (wdt)
  );

  // Key pin synchroniser and edge history
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      key_meta <= 1'b1;
      key_sync <= 1'b1;
      key_prev <= 1'b1;
    end
    else if (clk_en)
    begin
      key_meta <= key_pin;
      key_sync <= key_meta;
      key_prev <= key_sync;
    end
  end

  // Decoded conditions
  assign key_fall      = key_prev & ~key_sync;
  assign base_expire   = (state == S_BASE) && (base_tick_count == 8'h01);
  assign next_period   = period_count - 8'h01;
  assign interval_done = base_expire && (next_period == 8'h00);
  assign next_press    = (press_count >= LAST_IDX) ? 8'h00
                                                   : press_count + 8'h01;
  assign ev_press      = (state == S_DEB) && (debounce_count == 8'h01)
                         && !key_sync;
  assign ev_interval   = interval_done;
  assign ev_calib      = (state == S_CALC);
  assign wdt.clear     = base_expire;  // Restart period measurement

  // Ticks closest to the base unit, rounded and clamped
  always_comb
  begin
    quotient = (32'(BASE_RATIO) + 32'(measure_counter >> 1))
               / 32'(measure_counter);
    if (quotient > 32'(BASE_MAX))
      calc_value = BASE_MAX;
    else if (quotient < 32'(BASE_MIN))
      calc_value = BASE_MIN;
    else
      calc_value = quotient[7:0];
  end

  // Tick sequencer: calibrate, debounce, base count
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      state <= S_IDLE;
    else if (clk_en)
    begin
      unique case (state)
        S_IDLE:
          if (wdt.tick)
            state <= (handler_select == H_MEASURE) ? S_CALC : S_DEB;
        S_CALC: state <= S_DEB;
        S_DEB:  state <= S_BASE;
        S_BASE: state <= S_IDLE;
      endcase
    end
  end

  // Handler selection, measurement first after reset
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      handler_select <= H_MEASURE;
    else if (clk_en)
    begin
      if (state == S_CALC)
        handler_select <= H_DEBOUNCE;
      else if (base_expire)
        handler_select <= H_MEASURE;
    end
  end

  // Measurement counter: one step per 87 core clocks, saturating
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      measure_counter <= MEAS_PRELOAD;
      step_count      <= '0;
    end
    else if (clk_en)
    begin
      if (base_expire)
      begin
        measure_counter <= MEAS_PRELOAD;
        step_count      <= '0;
      end
      else if (handler_select == H_MEASURE && state == S_IDLE)
      begin
        if (step_count == STEP_LAST)
        begin
          step_count <= '0;
          if (measure_counter != MEAS_MAX)
            measure_counter <= measure_counter + 16'h0001;
        end
        else
          step_count <= step_count + SW'(1);
      end
    end
  end

  // Debounce counter and key edge enable
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      debounce_count <= 8'h00;
      key_irq_en     <= 1'b1;
    end
    else if (clk_en)
    begin
      if (key_irq_en && key_fall)
      begin
        debounce_count <= DEBOUNCE_TICKS;
        key_irq_en     <= 1'b0;
      end
      else if (state == S_DEB && debounce_count != 8'h00)
      begin
        debounce_count <= debounce_count - 8'h01;
        if (debounce_count == 8'h01)
          key_irq_en <= 1'b1;
      end
    end
  end

  // Press counter on confirmed low key
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      press_count <= 8'h00;
    else if (clk_en && ev_press)
      press_count <= next_press;
  end

  // Base and interval counting, LED toggle
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      base_tick_count <= 8'h00;
      period_count    <= TABLE_INIT[0];
      led             <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state == S_CALC)
        base_tick_count <= calc_value - 8'h01;
      else if (state == S_BASE)
      begin
        base_tick_count <= base_tick_count - 8'h01;
        if (base_expire)
        begin
          if (interval_done)
          begin
            period_count <= interval_table[press_count[IW-1:0]];
            led          <= ~led;
          end
          else
            period_count <= next_period;
        end
      end
    end
  end

  // Interval table, software writable
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < TABLE_DEPTH; i++)
        interval_table[i] <= TABLE_INIT[i];
    end
    else if (clk_en && wr)
    begin
      for (int i = 0; i < TABLE_DEPTH; i++)
        if (addr == REG_TABLE + 8'(4 * i))
          interval_table[i] <= wdata[7:0];
    end
  end

  // Sticky status, write one to clear, set wins
  assign w1c = (wr && addr == REG_STATUS) ? wdata[STATUS_W-1:0] : '0;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      status <= '0;
      mask   <= '0;
      irq    <= 1'b0;
    end
    else if (clk_en)
    begin
      status <= (status & ~w1c)
                | {ev_calib, ev_press, ev_interval};
      if (wr && addr == REG_MASK)
        mask <= wdata[STATUS_W-1:0];
      irq <= |(status & mask);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      rdata <= 32'h0000_0000;
    else if (clk_en)
    begin
      rdata <= 32'h0000_0000;
      if (rd)
      begin
        if (addr == REG_STATUS)
          rdata <= 32'(status);
        else if (addr == REG_MASK)
          rdata <= 32'(mask);
        else if (addr == REG_STATE)
          rdata <= {6'h00, key_irq_en, handler_select, led, 7'h00,
                    press_count, base_tick_count[7:0]} ^
                   {24'h000000, 8'h00};
        else if (addr == REG_MEAS)
          rdata <= {period_count, debounce_count, measure_counter};
        else
          for (int i = 0; i < TABLE_DEPTH; i++)
            if (addr == REG_TABLE + 8'(4 * i))
              rdata <= {24'h000000, interval_table[i]};
      end
    end
  end

  // Checks
  a_debounce_dec: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (state == S_DEB && debounce_count != 8'h00 && clk_en)
      |=> debounce_count == $past(debounce_count) - 8'h01)
    else $error("debounce count did not decrement");

  a_debounce_skip: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (state == S_DEB && clk_en) |=>
      (state == S_BASE) and (clk_en |=> state == S_IDLE))
    else $error("tick handling did not reach base counting");

  a_key_reenable: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (state == S_DEB && debounce_count == 8'h01 && clk_en) |=> key_irq_en)
    else $error("key edge not re-enabled after debounce");

  a_press_step: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (ev_press && clk_en) |=>
      press_count == (($past(press_count) >= LAST_IDX) ? 8'h00
                      : $past(press_count) + 8'h01))
    else $error("press count did not step or wrap");

  a_press_hold: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (state == S_DEB && debounce_count == 8'h01 && key_sync && clk_en)
      |=> $stable(press_count))
    else $error("press count changed with key released");

  a_led_toggle: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (interval_done && clk_en) |=>
      led != $past(led) && handler_select == H_MEASURE)
    else $error("interval end did not toggle led");

  a_meas_preload: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (base_expire && clk_en) |=> measure_counter == MEAS_PRELOAD)
    else $error("measurement counter not preloaded");

  a_calc_load: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (state == S_CALC && clk_en) |=>
      base_tick_count == $past(calc_value) - 8'h01
      && handler_select == H_DEBOUNCE && state == S_DEB)
    else $error("calibration load incorrect");

  a_debounce_load: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (key_irq_en && key_fall && clk_en) |=>
      debounce_count == DEBOUNCE_TICKS && !key_irq_en)
    else $error("key edge did not start debounce");

endmodule : calibrated_interval_timer

// [inc/interval_timer_pkg.sv]
package interval_timer_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS = 8;

  // Watchdog interval tick, 75 percent of its overflow time
  localparam int WDT_INTERVAL_NS = 3_200_000;
  localparam int WDT_TICK_CYC    = WDT_INTERVAL_NS / CLK_PERIOD_NS;

  // Measurement step: 87 clocks of the 125 MHz core
  localparam int MEAS_STEP_NS  = 700;
  localparam int MEAS_STEP_CYC = MEAS_STEP_NS / CLK_PERIOD_NS;

  // Base unit and its size in measurement steps
  localparam int BASE_PERIOD_NS = 100_000_000;
  localparam int BASE_RATIO     = BASE_PERIOD_NS / MEAS_STEP_NS;

  // Wake latency offset and measurement preload
  localparam logic [15:0] WAKE_OFFSET  = 16'h0028;
  localparam logic [15:0] MEAS_PRELOAD = WAKE_OFFSET + 16'h0001;
  localparam logic [15:0] MEAS_MAX     = 16'hFFFF;

  // Debounce delay in ticks
  localparam logic [7:0] DEBOUNCE_TICKS = 8'h09;

  // Least and greatest base count after calibration
  localparam logic [7:0] BASE_MIN = 8'h02;
  localparam logic [7:0] BASE_MAX = 8'hFF;

  // Interval table reset contents, entry zero is one unit
  localparam int TABLE_MAX = 8;
  localparam logic [7:0] TABLE_INIT [0:TABLE_MAX-1] =
    '{8'h01, 8'h02, 8'h03, 8'h05, 8'h0A, 8'h14, 8'h32, 8'h64};

  // Register offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_STATE  = 8'h08;
  localparam logic [7:0] REG_MEAS   = 8'h0C;
  localparam logic [7:0] REG_TABLE  = 8'h20;

  // Status bit positions
  localparam int STATUS_W    = 3;
  localparam int ST_INTERVAL = 0;
  localparam int ST_PRESS    = 1;
  localparam int ST_CALIB    = 2;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_CALC = 2'b01,
    S_DEB  = 2'b10,
    S_BASE = 2'b11
  } fsm_state_t;

  typedef enum logic {
    H_DEBOUNCE = 1'b0,
    H_MEASURE  = 1'b1
  } handler_t;

endpackage : interval_timer_pkg

// [inc/wdt_if.sv]
`timescale 1ns/1ps
interface wdt_if;
  logic clear;
  logic tick;
  modport ctrl (output clear, input tick);
  modport unit (input clear, output tick);
endinterface : wdt_if

// [hdl/watchdog_unit.sv]
`timescale 1ns/1ps
module watchdog_unit
#(
  parameter int TICK_CYCLES = interval_timer_pkg::WDT_TICK_CYC
)
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  wdt_if.unit       wdt
);
  import interval_timer_pkg::*;

  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] count;

  // Free running from reset release, cleared on request
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      count    <= '0;
      wdt.tick <= 1'b0;
    end
    else if (clk_en)
    begin
      wdt.tick <= 1'b0;
      if (wdt.clear)
        count <= '0;
      else if (count == LAST)
      begin
        count    <= '0;
        wdt.tick <= 1'b1;  // One-cycle interval tick
      end
      else
        count <= count + CW'(1);
    end
  end

endmodule : watchdog_unit

// [test/key_switch_model.sv]
`timescale 1ns/1ps
// Push-button with pull-up: idles high, bounces on closing, held while pressed
module key_switch_model
(
  input  wire logic sys_clk,
  input  wire logic press,
  output logic      key_pin
);
  int bounce = 0;

  // Closing contact chatters for six cycles, then stays low until released
  always @(posedge sys_clk)
  begin
    if (press && bounce < 6)
    begin
      key_pin <= bounce[0];
      bounce  <= bounce + 1;
    end
    else
    begin
      key_pin <= !press;
      if (!press)
        bounce <= 0;
    end
  end
endmodule : key_switch_model

// [test/calibrated_interval_timer_test.sv]
`timescale 1ns/1ps
module calibrated_interval_timer_test;
  import interval_timer_pkg::*;
  localparam int TICKS = 200;
  localparam int DEPTH = 4;
  localparam int LIMIT = 100000;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        clk_en  = 1'b1;
  logic        press   = 1'b0;
  logic        key_pin;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        rd_q    = 1'b0;
  logic [31:0] rdata;
  logic        led;
  logic        irq;
  logic [31:0] val;
  logic [63:0] note;
  logic [63:0] note_q [$];
  int          n_errors = 0;
  int          checked  = 0;
  int          cycles   = 0;

  calibrated_interval_timer #(.TICK_CYCLES(TICKS), .BASE_RATIO(430),
    .TABLE_DEPTH(DEPTH)) calibrated_interval_timer_i (.sys_clk(sys_clk),
    .resetn(resetn), .clk_en(clk_en), .key_pin(key_pin), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .led(led), .irq(irq));

  key_switch_model key_switch_model_i (.sys_clk(sys_clk), .press(press),
    .key_pin(key_pin));

  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask : check_bit

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Note the masked expectation, then issue a one-cycle read strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    note_q.push_back({m, e & m});
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
  endtask : rd_reg

  task automatic wait_irq(input int lim);
    int n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    check_bit(1'b1, irq);
  endtask : wait_irq

  // Read data stand only in the cycle after the strobe; oldest note first
  always @(posedge sys_clk)
  begin
    rd_q <= rd;
    cycles++;
    if (rd_q && note_q.size() > 0)
    begin
      note = note_q.pop_front();
      check_word(note[31:0], rdata & note[63:32]);
    end
    if (cycles == LIMIT)
    begin
      n_errors++;
      conclude();
    end
  end

  // Main sequence
  initial
  begin
    void'($urandom(4533));
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_reg(REG_STATE, 32'h0300_0000, 32'h0380_FF00);
    rd_reg(REG_MEAS, {8'h01, 8'h00, MEAS_PRELOAD}, '1);
    rd_reg(REG_STATUS, 32'h0, '1);
    check_bit(1'b0, led);
    check_bit(1'b0, irq);
    for (int i = 0; i < DEPTH; i++)
      rd_reg(REG_TABLE + 8'(4 * i), {24'h0, TABLE_INIT[i]}, '1);
    val = $urandom();
    wr_reg(REG_TABLE + 8'h0C, val);
    rd_reg(REG_TABLE + 8'h0C, {24'h0, val[7:0]}, '1);
    wr_reg(REG_TABLE + 8'h0C, {24'h0, TABLE_INIT[3]});
    rd_reg(8'h80, 32'h0, '1);
    // A strobe with the clock enable low is ignored
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr_reg(REG_MASK, 32'h7);
    clk_en <= 1'b1;
    rd_reg(REG_MASK, 32'h0, '1);
    // Calibration completes, then ticks return to debounce handling
    wr_reg(REG_MASK, 32'h4);
    wait_irq(20 * TICKS);
    // Two steps past preload give a base of ten, counted down twice
    rd_reg(REG_STATE, 32'h0000_0008, 32'h0100_00FF);
    wr_reg(REG_STATUS, 32'h4);
    repeat (2) @(posedge sys_clk);
    check_bit(1'b0, irq);
    // First interval of one unit ends: LED flips, interval reloads
    wr_reg(REG_MASK, 32'h1);
    wait_irq(20000);
    check_bit(1'b1, led);
    rd_reg(REG_MEAS, {TABLE_INIT[0], 24'h0}, 32'hFF00_0000);
    wr_reg(REG_MASK, 32'h2);
    wr_reg(REG_STATUS, 32'h7);
    repeat (2) @(posedge sys_clk);
    check_bit(1'b0, irq);
    // Short tap released before the sample: no press counted
    press <= 1'b1;
    repeat (100) @(posedge sys_clk);
    press <= 1'b0;
    repeat (20 * TICKS) @(posedge sys_clk);
    rd_reg(REG_STATE, 32'h0200_0000, 32'h0200_FF00);
    check_bit(1'b0, irq);
    // Held presses step the count through the table and wrap
    for (int k = 1; k <= DEPTH; k++)
    begin
      press <= 1'b1;
      repeat (1500) @(posedge sys_clk);
      rd_reg(REG_STATE, 32'(k - 1) << 8, 32'h0200_FF00);
      wait_irq(20 * TICKS);
      rd_reg(REG_STATE, 32'h0200_0000 | (32'(k % DEPTH) << 8),
             32'h0200_FF00);
      press <= 1'b0;
      wr_reg(REG_STATUS, 32'h2);
      repeat (2) @(posedge sys_clk);
      check_bit(1'b0, irq);
      repeat ($urandom_range(400, 200)) @(posedge sys_clk);
    end
    conclude();
  end
endmodule : calibrated_interval_timer_test
